// file: design/strap_consts.svh
// constants of the strap decoder: strap indices, register map, field positions
// assumes inclusion by the package, the design modules and the sim files
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH

`define NUM_STRAPS        4
`define STRAP_SWING       0
`define STRAP_EDGE        1
`define STRAP_MODE        2
`define STRAP_CAL         3

`define ADDR_W            8
`define CTRL_OFFSET       8'h00
`define STATUS_OFFSET     8'h04
`define LEVELS_OFFSET     8'h08

`define CTRL_HOLD_BIT     0
`define CTRL_RESET        1'h0

`define ST_SERIAL_BIT     0
`define ST_RANGE_BIT      1
`define ST_SWING_BIT      2
`define ST_EDGE_BIT       3
`define ST_DDR_BIT        4
`define ST_CAL_BIT        5
`define ST_SWING_BAD_BIT  6
`define ST_CAL_FLOAT_BIT  7

`define HSIZE_WORD        3'h2
`define HTRANS_NONSEQ_BIT 1

`endif

// file: design/strap_pkg.sv
// types shared by the strap decoder modules
// assumes strap_consts.svh is on the include path
`include "strap_consts.svh"

package strap_pkg;
	typedef enum logic [1:0] {
		LVL_LOW,
		LVL_HIGH,
		LVL_FLOAT
	} strap_level_e;
endpackage

// file: design/strap_if.sv
// carrier between the strap sensing front end and the decoder
// assumes both sides run on hclk
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

interface strap_if;
	strap_pkg::strap_level_e      level [`NUM_STRAPS];
	logic [`NUM_STRAPS-1:0]       pin_high;

	modport sense  (output level, output pin_high);
	modport decode (input level, input pin_high);
endinterface
`default_nettype wire

// file: design/strap_sense.sv
// three-level strap sensing: two comparator bits per pin, synchronised and resolved
// assumes the comparators are asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

module strap_sense (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic [`NUM_STRAPS-1:0] strap_above,
	input  wire logic [`NUM_STRAPS-1:0] strap_below,
	strap_if.sense                      st
);
	logic [`NUM_STRAPS-1:0] a1_r, a2_r, a3_r;
	logic [`NUM_STRAPS-1:0] b1_r, b2_r, b3_r;
	logic [`NUM_STRAPS-1:0] above_r, above_nxt;
	logic [`NUM_STRAPS-1:0] below_r, below_nxt;
	strap_pkg::strap_level_e level_r [`NUM_STRAPS];
	strap_pkg::strap_level_e level_nxt [`NUM_STRAPS];

	// both comparators tripped is a transient; keep the last clean decision
	function automatic strap_pkg::strap_level_e resolve(input logic above,
		input logic below, input strap_pkg::strap_level_e prev);
		if (above && !below)
			return strap_pkg::LVL_HIGH;
		else if (!above && below)
			return strap_pkg::LVL_LOW;
		else if (!above && !below)
			return strap_pkg::LVL_FLOAT;
		else
			return prev;
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a1_r <= '0;
			a2_r <= '0;
			a3_r <= '0;
			b1_r <= '1;
			b2_r <= '1;
			b3_r <= '1;
		end else begin
			a1_r <= strap_above;
			a2_r <= a1_r;
			a3_r <= a2_r;
			b1_r <= strap_below;
			b2_r <= b1_r;
			b3_r <= b2_r;
		end
	end

	always_comb begin
		for (int i = 0; i < `NUM_STRAPS; i++) begin
			above_nxt[i] = (a2_r[i] == a3_r[i]) ? a3_r[i] : above_r[i];
			below_nxt[i] = (b2_r[i] == b3_r[i]) ? b3_r[i] : below_r[i];
			level_nxt[i] = resolve(above_nxt[i], below_nxt[i], level_r[i]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			above_r <= '0;
			below_r <= '1;
			for (int i = 0; i < `NUM_STRAPS; i++)
				level_r[i] <= strap_pkg::LVL_LOW;
		end else begin
			above_r <= above_nxt;
			below_r <= below_nxt;
			for (int i = 0; i < `NUM_STRAPS; i++)
				level_r[i] <= level_nxt[i];
		end
	end

	assign st.level    = level_r;
	assign st.pin_high = above_r;
endmodule
`default_nettype wire

// file: design/control_mode_strap_decoder.sv
// strap decoder top: pin-controlled settings, serial pin reuse, ahb-lite registers
// assumes comparator pairs on each strap pin and a conversion-active level on hclk
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

// Overview of operation
// - a low or high mode strap gives pin control with small or large input range, floating gives serial control.
// - in pin control the serial port stays idle and settings follow only the strap levels.
// - in pin control the swing strap picks the small swing when low and the large when high; float is undefined.
// - in pin control a low edge strap launches data on the negative edge, a high one on the positive edge.
// - a floating edge strap selects double data rate and the edge choice is ignored.
// - in pin control the calibration strap picks the short delay when low and the long one when high.
// - a floating calibration strap gives the short delay and sets the cal_pin_float flag; the pin is the serial select only in serial control.
// - in serial control the swing, edge and calibration pins become serial clock, data and select.
module control_mode_strap_decoder (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire logic [`NUM_STRAPS-1:0] strap_above,
	input  wire logic [`NUM_STRAPS-1:0] strap_below,
	input  wire logic                   conversion_active,
	output logic                        serial_mode,
	output logic                        fs_range_large,
	output logic                        swing_large,
	output logic                        swing_undefined,
	output logic                        output_edge_select,
	output logic                        ddr_mode,
	output logic                        calibration_delay_select,
	output logic                        cal_pin_float,
	output logic                        serial_clock,
	output logic                        serial_data_line,
	output logic                        serial_select
);
	strap_if st ();

	strap_sense u_sense (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.strap_above (strap_above),
		.strap_below (strap_below),
		.st          (st)
	);

	// bus slave state
	logic                  hold_r, hold_nxt;
	logic                  wr_pend_r, wr_pend_nxt;
	logic [`ADDR_W-1:0]    wr_addr_r, wr_addr_nxt;
	logic [31:0]           hrdata_r, hrdata_nxt;
	logic                  addr_phase;

	// decoded settings
	logic serial_mode_r, serial_mode_nxt;
	logic range_r, range_nxt;
	logic swing_r, swing_nxt;
	logic swing_bad_r, swing_bad_nxt;
	logic edge_r, edge_nxt;
	logic ddr_r, ddr_nxt;
	logic cal_r, cal_nxt;
	logic cal_float_r, cal_float_nxt;
	logic sck_r, sck_nxt;
	logic sdat_r, sdat_nxt;
	logic ssel_r, ssel_nxt;
	logic upd;
	logic pin_sel;

	function automatic logic is_lvl(input strap_pkg::strap_level_e l,
		input strap_pkg::strap_level_e want);
		return l == want;
	endfunction

	assign upd     = !conversion_active && !hold_r;
	assign pin_sel = !is_lvl(st.level[`STRAP_MODE], strap_pkg::LVL_FLOAT);

	always_comb begin
		serial_mode_nxt = serial_mode_r;
		range_nxt       = range_r;
		swing_nxt       = swing_r;
		swing_bad_nxt   = swing_bad_r;
		edge_nxt        = edge_r;
		ddr_nxt         = ddr_r;
		cal_nxt         = cal_r;
		cal_float_nxt   = cal_float_r;
		if (upd) begin
			serial_mode_nxt = !pin_sel;
			if (pin_sel) begin
				// pin control: every setting comes from a strap level
				range_nxt     = is_lvl(st.level[`STRAP_MODE], strap_pkg::LVL_HIGH);
				swing_bad_nxt = is_lvl(st.level[`STRAP_SWING], strap_pkg::LVL_FLOAT);
				if (!swing_bad_nxt)
					swing_nxt = is_lvl(st.level[`STRAP_SWING], strap_pkg::LVL_HIGH);
				ddr_nxt = is_lvl(st.level[`STRAP_EDGE], strap_pkg::LVL_FLOAT);
				if (!ddr_nxt)
					edge_nxt = is_lvl(st.level[`STRAP_EDGE], strap_pkg::LVL_HIGH);
				cal_nxt       = is_lvl(st.level[`STRAP_CAL], strap_pkg::LVL_HIGH);
				cal_float_nxt = is_lvl(st.level[`STRAP_CAL], strap_pkg::LVL_FLOAT);
			end
		end
	end

	// serial pins are live only in serial control; select pin is active low
	always_comb begin
		sck_nxt  = serial_mode_r && st.pin_high[`STRAP_SWING];
		sdat_nxt = serial_mode_r && st.pin_high[`STRAP_EDGE];
		ssel_nxt = serial_mode_r && !st.pin_high[`STRAP_CAL];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_mode_r <= 1'b0;
			range_r       <= 1'b0;
			swing_r       <= 1'b0;
			swing_bad_r   <= 1'b0;
			edge_r        <= 1'b0;
			ddr_r         <= 1'b0;
			cal_r         <= 1'b0;
			cal_float_r   <= 1'b0;
			sck_r         <= 1'b0;
			sdat_r        <= 1'b0;
			ssel_r        <= 1'b0;
		end else begin
			serial_mode_r <= serial_mode_nxt;
			range_r       <= range_nxt;
			swing_r       <= swing_nxt;
			swing_bad_r   <= swing_bad_nxt;
			edge_r        <= edge_nxt;
			ddr_r         <= ddr_nxt;
			cal_r         <= cal_nxt;
			cal_float_r   <= cal_float_nxt;
			sck_r         <= sck_nxt;
			sdat_r        <= sdat_nxt;
			ssel_r        <= ssel_nxt;
		end
	end

	function automatic logic [31:0] read_word(input logic [`ADDR_W-1:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			`CTRL_OFFSET: begin
				w[`CTRL_HOLD_BIT] = hold_r;
			end
			`STATUS_OFFSET: begin
				w[`ST_SERIAL_BIT]    = serial_mode_r;
				w[`ST_RANGE_BIT]     = range_r;
				w[`ST_SWING_BIT]     = swing_r;
				w[`ST_EDGE_BIT]      = edge_r;
				w[`ST_DDR_BIT]       = ddr_r;
				w[`ST_CAL_BIT]       = cal_r;
				w[`ST_SWING_BAD_BIT] = swing_bad_r;
				w[`ST_CAL_FLOAT_BIT] = cal_float_r;
			end
			`LEVELS_OFFSET: begin
				for (int i = 0; i < `NUM_STRAPS; i++)
					w[2*i +: 2] = st.level[i];
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// zero wait states: read data is prepared during the address phase
	assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

	always_comb begin
		hold_nxt    = hold_r;
		wr_pend_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		hrdata_nxt  = hrdata_r;
		if (wr_pend_r && wr_addr_r == `CTRL_OFFSET)
			hold_nxt = hwdata[`CTRL_HOLD_BIT];
		if (addr_phase) begin
			wr_pend_nxt = hwrite && hsize == `HSIZE_WORD;
			wr_addr_nxt = haddr[`ADDR_W-1:0];
			if (!hwrite)
				hrdata_nxt = read_word(haddr[`ADDR_W-1:0]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_r    <= `CTRL_RESET;
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			hrdata_r  <= 32'h0000_0000;
		end else begin
			hold_r    <= hold_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata_r  <= hrdata_nxt;
		end
	end

	assign hreadyout                = 1'b1;
	assign hresp                    = 1'b0;
	assign hrdata                   = hrdata_r;
	assign serial_mode              = serial_mode_r;
	assign fs_range_large           = range_r;
	assign swing_large              = swing_r;
	assign swing_undefined          = swing_bad_r;
	assign output_edge_select       = edge_r;
	assign ddr_mode                 = ddr_r;
	assign calibration_delay_select = cal_r;
	assign cal_pin_float            = cal_float_r;
	assign serial_clock             = sck_r;
	assign serial_data_line         = sdat_r;
	assign serial_select            = ssel_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	mode_float_a: assert property (upd && !pin_sel |=> serial_mode_r)
		else $error("floating mode strap did not select serial control");
	mode_pin_a: assert property (upd && pin_sel |=> !serial_mode_r
		&& range_r == $past(is_lvl(st.level[`STRAP_MODE], strap_pkg::LVL_HIGH)))
		else $error("mode strap level gave wrong range");
	serial_idle_a: assert property (!serial_mode_r |=> !sck_r && !sdat_r && !ssel_r)
		else $error("serial pins active in pin control");
	// compare with the resolved level: with both comparators on the raw pin bit disagrees
	swing_sel_a: assert property (upd && pin_sel
		&& !is_lvl(st.level[`STRAP_SWING], strap_pkg::LVL_FLOAT)
		|=> !swing_bad_r
		&& swing_r == $past(is_lvl(st.level[`STRAP_SWING], strap_pkg::LVL_HIGH)))
		else $error("swing setting does not follow strap");
	edge_sel_a: assert property (upd && pin_sel
		&& !is_lvl(st.level[`STRAP_EDGE], strap_pkg::LVL_FLOAT)
		|=> !ddr_r
		&& edge_r == $past(is_lvl(st.level[`STRAP_EDGE], strap_pkg::LVL_HIGH)))
		else $error("output edge does not follow strap");
	ddr_float_a: assert property (upd && pin_sel
		&& is_lvl(st.level[`STRAP_EDGE], strap_pkg::LVL_FLOAT)
		|=> ddr_r && $stable(edge_r))
		else $error("floating edge strap did not give double rate");
	cal_sel_a: assert property (upd && pin_sel
		|=> cal_r == $past(is_lvl(st.level[`STRAP_CAL], strap_pkg::LVL_HIGH)))
		else $error("calibration delay does not follow strap");
	cal_float_a: assert property (upd && pin_sel
		&& is_lvl(st.level[`STRAP_CAL], strap_pkg::LVL_FLOAT)
		|=> !cal_r && cal_float_r)
		else $error("floating calibration strap mishandled");
	serial_pins_a: assert property (serial_mode_r
		|=> sck_r == $past(st.pin_high[`STRAP_SWING])
		&& sdat_r == $past(st.pin_high[`STRAP_EDGE])
		&& ssel_r == !$past(st.pin_high[`STRAP_CAL]))
		else $error("serial pins not passed through");
	hold_stable_a: assert property (conversion_active |=> $stable(serial_mode_r)
		&& $stable(range_r) && $stable(swing_r) && $stable(edge_r)
		&& $stable(ddr_r) && $stable(cal_r))
		else $error("settings changed during conversion");
endmodule
`default_nettype wire

// file: sim/strap_host_model.sv
// host side of the strap pins: comparator pairs per pin and slow serial frames
// assumes tasks are called from one bench process running on hclk
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

module strap_host_model #(
	parameter int HALF     = 6,
	parameter int NUM_REGS = 6
) (
	input  wire logic                   hclk,
	output logic [`NUM_STRAPS-1:0]      strap_above,
	output logic [`NUM_STRAPS-1:0]      strap_below
);
	logic [7:0] lvl = 8'h00;

	// code 3 turns both comparators on, as a pin slewing through the band does
	always_comb begin
		for (int i = 0; i < `NUM_STRAPS; i++) begin
			strap_above[i] = lvl[2*i+:2] == strap_pkg::LVL_HIGH || lvl[2*i+:2] == 2'h3;
			strap_below[i] = lvl[2*i+:2] == strap_pkg::LVL_LOW || lvl[2*i+:2] == 2'h3;
		end
	end

	task automatic set_straps(input logic [7:0] v);
		@(posedge hclk);
		lvl <= v;
	endtask

	task automatic drive(input int idx, input strap_pkg::strap_level_e v, input int n);
		@(posedge hclk);
		lvl[2*idx+:2] <= v;
		repeat (n - 1) @(posedge hclk);
	endtask

	// only meaningful with the mode strap floating; half period of 6 cycles, just above the five-edge sync delay
	task automatic write_all_regs();
		for (int a = 0; a < NUM_REGS; a++) begin
			drive(`STRAP_CAL, strap_pkg::LVL_LOW, HALF);
			for (int b = 7; b >= 0; b--) begin
				drive(`STRAP_EDGE, ((8'(a) | 8'ha0) >> b) & 8'h01 ? strap_pkg::LVL_HIGH
					: strap_pkg::LVL_LOW, 1);
				drive(`STRAP_SWING, strap_pkg::LVL_HIGH, HALF);
				drive(`STRAP_SWING, strap_pkg::LVL_LOW, HALF);
			end
			drive(`STRAP_CAL, strap_pkg::LVL_HIGH, HALF);
		end
	endtask
endmodule
`default_nettype wire

// file: sim/control_mode_strap_decoder_test.sv
// self-checking bench: strap table, bus registers, hold/freeze, serial frames
// assumes the decoder has zero-wait ahb-lite and a five-edge strap latency
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

module control_mode_strap_decoder_test;
	logic                   hclk, hresetn, hsel, hwrite, conversion_active;
	logic [31:0]            haddr, hwdata, rd;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	wire logic              hreadyout, hresp, hready;
	wire logic [31:0]       hrdata;
	wire logic [3:0]        above, below;
	wire logic [10:0]       outs;
	logic [7:0]             row_lvl [7] = '{8'h00, 8'h55, 8'h9a, 8'h40, 8'h21, 8'h64, 8'h05};
	logic [10:0]            row_exp [7] = '{11'h000, 11'h350, 11'h3e8, 11'h010, 11'h405,
	                                        11'h402, 11'h140};
	logic [10:0]            e;
	logic                   sclk_q, ssel_q;
	int                     n_clk, n_sel, num_errors, tests_run;

	assign hready = hreadyout;
	control_mode_strap_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.strap_above(above), .strap_below(below), .conversion_active(conversion_active),
		.serial_mode(outs[10]), .fs_range_large(outs[9]), .swing_large(outs[8]),
		.swing_undefined(outs[7]), .output_edge_select(outs[6]), .ddr_mode(outs[5]),
		.calibration_delay_select(outs[4]), .cal_pin_float(outs[3]),
		.serial_clock(outs[2]), .serial_data_line(outs[1]), .serial_select(outs[0]));
	strap_host_model host (.hclk(hclk), .strap_above(above), .strap_below(below));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		sclk_q <= outs[2];
		ssel_q <= outs[0];
		if (outs[2] === 1'b1 && sclk_q === 1'b0) n_clk++;
		if (outs[0] === 1'b1 && ssel_q === 1'b0) n_sel++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		input logic [2:0] sz);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic settle(input logic [7:0] v);
		host.set_straps(v);
		repeat (8) @(posedge hclk);
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		conclude();
	end

	initial begin
		{hresetn, hsel, hwrite, conversion_active, haddr, hwdata, htrans} = '0;
		hsize = `HSIZE_WORD;
		repeat (6) @(posedge hclk);
		chk({hreadyout, hresp, outs}, {2'b10, 11'h000});
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			e = row_exp[i];
			settle(row_lvl[i]);
			chk(32'(outs & (e[10] ? 11'h407 : 11'h7ff)), 32'(e));
			ahb(1'b0, `STATUS_OFFSET, 32'h0, `HSIZE_WORD);
			chk(rd & {24'h0, e[10] ? 8'h01 : 8'hff},
				{24'h0, e[3], e[7], e[4], e[5], e[6], e[8], e[9], e[10]});
			ahb(1'b0, `LEVELS_OFFSET, 32'h0, `HSIZE_WORD);
			chk(rd, {24'h0, row_lvl[i]});
		end
		// hold register freezes settings; narrow writes and read-only writes are dropped
		ahb(1'b1, `CTRL_OFFSET, 32'h1, `HSIZE_WORD);
		ahb(1'b0, `CTRL_OFFSET, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h1);
		settle(8'h55);
		chk(32'(outs), 32'h140);
		ahb(1'b1, `CTRL_OFFSET, 32'h0, 3'h0);
		ahb(1'b0, `CTRL_OFFSET, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h1);
		ahb(1'b1, `CTRL_OFFSET, 32'h0, `HSIZE_WORD);
		repeat (8) @(posedge hclk);
		chk(32'(outs), 32'h350);
		ahb(1'b1, `STATUS_OFFSET, 32'hff, `HSIZE_WORD);
		ahb(1'b0, `STATUS_OFFSET, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h2e);
		ahb(1'b0, 8'h0c, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h0);
		// conversion in progress freezes settings
		@(posedge hclk) conversion_active <= 1'b1;
		settle(8'h00);
		chk(32'(outs), 32'h350);
		@(posedge hclk) conversion_active <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(32'(outs), 32'h000);
		// both comparators on keeps the previous level
		settle(8'hff);
		ahb(1'b0, `LEVELS_OFFSET, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h0);
		settle(8'h60);
		chk(32'(outs & 11'h407), 32'h400);
		n_clk = 0;
		n_sel = 0;
		host.write_all_regs();
		repeat (8) @(posedge hclk);
		chk(32'(n_clk), 32'd48);
		chk(32'(n_sel), 32'd6);
		// mid-run reset clears settings and the hold bit, then the straps are taken again
		ahb(1'b1, `CTRL_OFFSET, 32'h1, `HSIZE_WORD);
		@(posedge hclk) hresetn <= 1'b0;
		@(posedge hclk);
		chk(32'(outs), 32'h000);
		@(posedge hclk) hresetn <= 1'b1;
		ahb(1'b0, `CTRL_OFFSET, 32'h0, `HSIZE_WORD);
		chk(rd, 32'h0);
		repeat (8) @(posedge hclk);
		chk(32'(outs & 11'h407), 32'h402);
		conclude();
	end
endmodule
`default_nettype wire
